//--- rtl/iack_pkg.sv
// constants and carrier types for the interrupt acknowledge block
// assumes a 32-bit apb register bus; register indices are word numbers (byte address = 4 x index)
package iack_pkg;

	// apb geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;

	// register indices
	localparam logic [7:0] IDX_ACK = 8'h00;
	localparam logic [7:0] IDX_CTRL = 8'h01;
	localparam logic [7:0] IDX_SP = 8'h02;
	localparam logic [7:0] IDX_STAT = 8'h03;
	localparam logic [7:0] IDX_CLR = 8'h04;
	localparam logic [7:0] IDX_EN = 8'h05;
	localparam logic [7:0] IDX_TIMER_A0_INTERRUPT_CONTROL = 8'h55;
	localparam logic [7:0] IDX_CTL_BASE = 8'h52;
	localparam int TIMER_A0_SRC = 3;

	// per-source control register fields
	localparam int LVL_LSB = 0;
	localparam int LVL_W = 3;
	localparam int REQ_BIT = 3;
	localparam int POL_BIT = 4;

	// acknowledge word fields
	localparam int NUM_W = 5;
	localparam int ACK_NUM_LSB = 0;
	localparam int ACK_LVL_LSB = 8;

	// global control register fields
	localparam int IEN_BIT = 0;
	localparam int IPL_LSB = 1;

	// stack pointer
	localparam int SP_W = 20;
	localparam logic [19:0] SP_RST = 20'h00000;

	// status events
	localparam int EV_W = 3;
	localparam int EV_REQ = 0;
	localparam int EV_NMI = 1;
	localparam int EV_EMPTY = 2;

	typedef struct packed {
		logic pol;
		logic req;
		logic [2:0] lvl;
	} iack_ctl_t;

	localparam iack_ctl_t CTL_RST = 5'h00;

	typedef struct packed {
		logic hit;
		logic [2:0] lvl;
		logic [4:0] num;
	} iack_win_t;

endpackage

//--- rtl/iack_ctrl.sv
// interrupt request latching, priority select, acknowledge read and nmi for a small cpu
// assumes apb master on i_clk, synchronous source inputs, cpu reads the ack word over apb
//
// Operation
// RULE1 - acknowledge read returns winner number and level
// RULE2 - acknowledge read clears the returned request bit
// RULE3 - any acknowledge read clears highest pending request
// RULE4 - software must not read acknowledge address
// RULE5 - stack pointer resets to zero
// RULE6 - software loads stack pointer before interrupts
// RULE7 - no interrupt during first instruction
// RULE8 - nmi cannot be masked or disabled
// RULE9 - polarity change may set external request
// RULE10 - software clears request after polarity change
// RULE11 - rewrite control only when source idle
// RULE12 - enable flag may precede pending control write
// RULE13 - request arriving during rewrite is kept
// RULE14 - request latched; highest level above cpu wins
`timescale 1ns/10ps
module iack_ctrl #(
	parameter int NSRC = 8,
	parameter int NEXT = 3
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// interrupt sources
	input wire logic [NEXT-1:0] i_ext_int,
	input wire logic [NSRC-NEXT-1:0] i_periph_req,
	input wire logic i_nmi_n,
	input wire logic i_nmi_ack,
	// cpu side
	output logic o_int_req,
	output logic [2:0] o_int_lvl,
	output logic [4:0] o_int_num,
	output logic o_nmi_req,
	output logic [19:0] o_sp,
	output logic o_irq
);

	iack_pkg::iack_ctl_t ctl_ff [NSRC];
	iack_pkg::iack_win_t win;
	iack_pkg::iack_win_t ack_ff;
	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic ien_ff;
	logic [2:0] ipl_ff;
	logic [19:0] sp_ff;
	logic [2:0] stat_ff;
	logic [2:0] en_ff;
	logic irq_ff;
	logic nmi_prev_ff;
	logic nmi_pend_ff;
	logic int_req_ff;
	logic [2:0] int_lvl_ff;
	logic [4:0] int_num_ff;
	logic nxt_pready;
	logic fire;
	logic wr_fire;
	logic rd_fire;
	logic aligned;
	logic [7:0] idx;
	logic [NSRC-1:0] ctl_sel;
	logic [NSRC-1:0] hw_set;
	logic [31:0] rd_val;
	logic rd_err;
	logic ack_clr;
	logic nmi_edge;
	logic [2:0] ev;

	// bus decode: answer comes one cycle into the access phase
	assign idx = i_paddr[9:2];
	assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
	assign nxt_pready = i_psel & i_penable & ~pready_ff;
	assign fire = i_psel & i_penable & pready_ff;
	assign wr_fire = fire & i_pwrite & aligned & ~pslverr_ff;
	assign rd_fire = fire & ~i_pwrite;

	// per-source request latching and control register storage
	for (genvar g = 0; g < NSRC; g++) begin : g_src
		logic trig;
		logic wr_here;
		assign ctl_sel[g] = (idx == 8'(int'(iack_pkg::IDX_CTL_BASE) + g));
		assign wr_here = wr_fire & ctl_sel[g];
		if (g < NEXT) begin : g_ext
			logic eff;
			logic prev_ff;
			// pol flips the compared level, so a polarity write can look like an edge
			assign eff = i_ext_int[g] ^ ctl_ff[g].pol;
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					prev_ff <= 1'b0;
				end else begin
					prev_ff <= eff;
				end
			end
			assign trig = eff & ~prev_ff; // RULE9
		end else begin : g_per
			assign trig = i_periph_req[g-NEXT];
		end
		assign hw_set[g] = trig;
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				ctl_ff[g] <= iack_pkg::CTL_RST;
			end else begin
				if (wr_here) begin
					ctl_ff[g].lvl <= i_pwdata[iack_pkg::LVL_LSB +: iack_pkg::LVL_W];
					ctl_ff[g].pol <= (g < NEXT) ? i_pwdata[iack_pkg::POL_BIT] : 1'b0;
				end
				// hardware set beats software write and ack clear
				if (trig) begin
					ctl_ff[g].req <= 1'b1; // RULE13 RULE14
				end else if (wr_here) begin
					ctl_ff[g].req <= i_pwdata[iack_pkg::REQ_BIT];
				end else if (ack_clr && ack_ff.hit && ack_ff.num == 5'(g)) begin
					ctl_ff[g].req <= 1'b0; // RULE2 RULE3
				end
			end
		end
	end

	// priority select: strict compare keeps the lowest number on equal levels
	always_comb begin
		win = '0;
		for (int k = 0; k < NSRC; k++) begin
			if (ctl_ff[k].req && ctl_ff[k].lvl > win.lvl) begin
				win.hit = 1'b1; // RULE14
				win.lvl = ctl_ff[k].lvl;
				win.num = 5'(k);
			end
		end
	end

	// read mux; ack word is the live winner, same for cpu and software reads
	always_comb begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		if (!aligned) begin
			rd_err = 1'b1;
		end else begin
			case (idx)
				iack_pkg::IDX_ACK: begin
					rd_val[iack_pkg::ACK_NUM_LSB +: iack_pkg::NUM_W] = win.num; // RULE1
					rd_val[iack_pkg::ACK_LVL_LSB +: iack_pkg::LVL_W] = win.lvl;
				end
				iack_pkg::IDX_CTRL: begin
					rd_val[iack_pkg::IEN_BIT] = ien_ff;
					rd_val[iack_pkg::IPL_LSB +: iack_pkg::LVL_W] = ipl_ff;
				end
				iack_pkg::IDX_SP: rd_val[iack_pkg::SP_W-1:0] = sp_ff;
				iack_pkg::IDX_STAT: rd_val[iack_pkg::EV_W-1:0] = stat_ff;
				iack_pkg::IDX_CLR: rd_val = 32'h00000000;
				iack_pkg::IDX_EN: rd_val[iack_pkg::EV_W-1:0] = en_ff;
				default: begin
					rd_err = ~(|ctl_sel);
					for (int k = 0; k < NSRC; k++) begin
						if (ctl_sel[k]) begin
							rd_val[4:0] = ctl_ff[k];
						end
					end
				end
			endcase
		end
	end

	// apb answer registers; ack winner is frozen with the read data
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
			ack_ff <= '0;
		end else begin
			pready_ff <= nxt_pready;
			if (nxt_pready) begin
				prdata_ff <= i_pwrite ? 32'h00000000 : rd_val;
				pslverr_ff <= rd_err;
				ack_ff <= win;
			end else begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	// freezing the winner at data capture avoids clearing a source that was not returned
	assign ack_clr = rd_fire & aligned & (idx == iack_pkg::IDX_ACK); // RULE3

	// global enable, cpu level and stack pointer; writes all land at the same edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ien_ff <= 1'b0;
			ipl_ff <= 3'h0;
			sp_ff <= iack_pkg::SP_RST; // RULE5
		end else begin
			if (wr_fire && idx == iack_pkg::IDX_CTRL) begin
				ien_ff <= i_pwdata[iack_pkg::IEN_BIT]; // RULE12
				ipl_ff <= i_pwdata[iack_pkg::IPL_LSB +: iack_pkg::LVL_W];
			end
			if (wr_fire && idx == iack_pkg::IDX_SP) begin
				sp_ff <= i_pwdata[iack_pkg::SP_W-1:0];
			end
		end
	end

	// nmi: falling edge latched, no enable anywhere in its path
	assign nmi_edge = nmi_prev_ff & ~i_nmi_n;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nmi_prev_ff <= 1'b1;
			nmi_pend_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= i_nmi_n;
			if (nmi_edge) begin
				nmi_pend_ff <= 1'b1; // RULE8
			end else if (i_nmi_ack) begin
				nmi_pend_ff <= 1'b0;
			end
		end
	end

	// maskable request to the cpu
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_req_ff <= 1'b0;
			int_lvl_ff <= 3'h0;
			int_num_ff <= 5'h00;
		end else begin
			int_req_ff <= ien_ff & win.hit & (win.lvl > ipl_ff); // RULE14
			int_lvl_ff <= win.lvl;
			int_num_ff <= win.num;
		end
	end

	// sticky event status; an event in the clearing cycle survives
	assign ev[iack_pkg::EV_REQ] = |hw_set;
	assign ev[iack_pkg::EV_NMI] = nmi_edge;
	assign ev[iack_pkg::EV_EMPTY] = ack_clr & ~ack_ff.hit;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stat_ff <= 3'h0;
			en_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			if (wr_fire && idx == iack_pkg::IDX_CLR) begin
				stat_ff <= (stat_ff & ~i_pwdata[iack_pkg::EV_W-1:0]) | ev;
			end else begin
				stat_ff <= stat_ff | ev;
			end
			if (wr_fire && idx == iack_pkg::IDX_EN) begin
				en_ff <= i_pwdata[iack_pkg::EV_W-1:0];
			end
			irq_ff <= |(stat_ff & en_ff);
		end
	end

	// outputs straight from flops
	assign o_pready = pready_ff;
	assign o_prdata = prdata_ff;
	assign o_pslverr = pslverr_ff;
	assign o_int_req = int_req_ff;
	assign o_int_lvl = int_lvl_ff;
	assign o_int_num = int_num_ff;
	assign o_nmi_req = nmi_pend_ff;
	assign o_sp = sp_ff;
	assign o_irq = irq_ff;

endmodule

//--- sim/iack_cpu_model.sv
// cpu and source model for iack_ctrl: nmi pin, nmi acknowledge, peripheral pulses
// assumes bench commands change just after rising edges of i_clk
`timescale 1ns/10ps
module iack_cpu_model #(
	parameter int ACK_DLY = 3
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// bench commands
	input wire logic i_nmi_go,
	input wire logic [4:0] i_fire,
	// device side
	input wire logic i_nmi_req,
	output logic o_nmi_n,
	output logic o_nmi_ack,
	output logic [4:0] o_periph_req
);
	int cnt_ff;
	// pin rests high as with its pull-up; a slow cpu answers nmi ACK_DLY+1 cycles after the request rises
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_nmi_n <= 1'b1;
			o_periph_req <= 5'h00;
			cnt_ff <= 0;
			o_nmi_ack <= 1'b0;
		end else begin
			o_nmi_n <= !i_nmi_go;
			o_periph_req <= i_fire;
			cnt_ff <= (i_nmi_req && cnt_ff < ACK_DLY) ? cnt_ff + 1 : 0;
			o_nmi_ack <= i_nmi_req && cnt_ff == ACK_DLY;
		end
	end
endmodule

//--- sim/iack_assertions.sv
// port checker for iack_ctrl: apb handshake, nmi latch and stack pointer
// assumes it is bound to every iack_ctrl instance
`timescale 1ns/10ps
module iack_chk (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// watched ports
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_nmi_n,
	input wire logic i_nmi_ack,
	input wire logic o_nmi_req,
	input wire logic [19:0] o_sp
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// apb answer shape: one wait state, one-cycle ready, error only with ready
	AST_RDY: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
		else $error("ready not in second access cycle");
	AST_RDY1: assert property (o_pready |=> !o_pready) else $error("ready held too long");
	AST_ERR: assert property (o_pslverr |-> o_pready) else $error("error without ready");
	// nmi has no mask: an edge always latches and stays until acknowledged
	AST_NMI: assert property ($fell(i_nmi_n) |=> o_nmi_req)
		else $error("nmi edge lost");
	AST_NMI_HOLD: assert property (o_nmi_req && !i_nmi_ack |=> o_nmi_req)
		else $error("nmi dropped early");
	AST_NMI_CLR: assert property (i_nmi_ack && !$fell(i_nmi_n) |=> !o_nmi_req)
		else $error("nmi ack ignored");
	// stack pointer starts at zero and moves only on a completed transfer
	AST_SP_RST: assert property ($rose(i_rst_n) |-> o_sp == 20'h00000)
		else $error("stack pointer not zero after reset");
	AST_SP_HOLD: assert property (!(i_psel && i_penable && o_pready) |=> $stable(o_sp))
		else $error("stack pointer moved");
endmodule
bind iack_ctrl iack_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
	.i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_nmi_n(i_nmi_n),
	.i_nmi_ack(i_nmi_ack), .o_nmi_req(o_nmi_req), .o_sp(o_sp));

//--- sim/tb.sv
// self-checking bench for iack_ctrl over apb
// assumes the cpu and source model of iack_cpu_model
`timescale 1ns/10ps
module tb;
	logic i_clk, i_rst_n, psel, pen, pwr, pready, se, slverr, int_req, nmi_req, irq;
	logic nmi_n, nmi_ack, go;
	logic [11:0] addr;
	logic [31:0] wd, prdata, rd;
	logic [2:0] ext, lvl;
	logic [4:0] num, fire, preq;
	logic [19:0] sp;
	int err_count, num_checks, cyc;
	iack_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(slverr), .i_ext_int(ext), .i_periph_req(preq), .i_nmi_n(nmi_n),
		.i_nmi_ack(nmi_ack), .o_int_req(int_req), .o_int_lvl(lvl), .o_int_num(num),
		.o_nmi_req(nmi_req), .o_sp(sp), .o_irq(irq));
	iack_cpu_model cpu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_nmi_go(go), .i_fire(fire),
		.i_nmi_req(nmi_req), .o_nmi_n(nmi_n), .o_nmi_ack(nmi_ack), .o_periph_req(preq));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; waits on ready rather than trusting the wait-state count
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		se = slverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard, far above the roughly 150 cycles the tests need
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		{psel, pen, pwr, go, i_rst_n} = 5'h00;
		{addr, wd, ext, fire} = 52'h0;
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rdc(12'h008, 32'h0);
		xfer(1'b1, 12'h008, 32'h0002a5c0);
		rdc(12'h008, 32'h0002a5c0);
		$display("reset test done");
		xfer(1'b1, 12'h154, 32'h05);
		xfer(1'b1, 12'h158, 32'h02);
		@(posedge i_clk) fire <= 5'h03;
		@(posedge i_clk) fire <= 5'h00;
		rdc(12'h154, 32'h0d);
		xfer(1'b1, 12'h004, 32'h0b);
		rdc(12'h004, 32'h0b);
		chk(int_req, 1'b0);
		xfer(1'b1, 12'h004, 32'h01);
		rdc(12'h004, 32'h01);
		chk({int_req, lvl, num}, {1'b1, 3'h5, 5'h03});
		rdc(12'h000, 32'h0503);
		rdc(12'h154, 32'h05);
		rdc(12'h000, 32'h0204);
		rdc(12'h158, 32'h02);
		rdc(12'h000, 32'h0);
		$display("acknowledge test done");
		xfer(1'b1, 12'h148, 32'h11);
		rdc(12'h148, 32'h19);
		xfer(1'b1, 12'h148, 32'h11);
		rdc(12'h148, 32'h11);
		xfer(1'b1, 12'h004, 32'h0);
		@(posedge i_clk) go <= 1'b1;
		@(posedge i_clk) go <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk(nmi_req, 1'b1);
		repeat (8) @(posedge i_clk);
		chk(nmi_req, 1'b0);
		$display("polarity and nmi tests done");
		rdc(12'h00c, 32'h07);
		chk(irq, 1'b0);
		xfer(1'b1, 12'h014, 32'h02);
		rdc(12'h014, 32'h02);
		chk(irq, 1'b1);
		xfer(1'b1, 12'h010, 32'h07);
		xfer(1'b1, 12'h014, 32'h07);
		rdc(12'h00c, 32'h0);
		chk(irq, 1'b0);
		rdc(12'h010, 32'h0);
		xfer(1'b0, 12'h400, 32'h0);
		chk(se, 1'b1);
		chk(rd, 32'h0);
		xfer(1'b1, 12'h0fc, 32'h01);
		chk(se, 1'b1);
		$display("status and error tests done");
		complete_run();
	end
endmodule
